// >>> verilog/dmfm_top.sv
// Drive motion fault monitor: amplifier fault and drag/stick check on every twentieth control tick
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dmfm_regs.svh"
module dmfm_top #(
  parameter int TICK_CYCLES = `DMFM_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Converter and multiplexer
  output logic      [15:0] out_port,
  output logic             convert_start_strobe,
  input  wire logic        conversion_done_flag,
  input  wire logic [11:0] velocity_sample,
  // Servo amplifier
  output logic             amp_fault_read_strobe,
  input  wire logic [15:0] amp_fault_in,
  // Position sensor
  input  wire logic [15:0] current_position,
  // Drive control and interrupt
  output logic             drive_stop_request,
  output logic             irq
);
  logic [2:0]          ctrl_reg;
  logic [15:0]         main_fault_word;
  logic [15:0]         amplifier_fault_word;
  logic [2:0]          irq_stat_reg;
  logic [2:0]          irq_mask_reg;
  logic [15:0]         previous_position;
  logic [15:0]         pos_tick_reg;
  logic [11:0]         previous_scaled_velocity;
  logic [11:0]         vel_motion_reg;
  logic [16:0]         pos_diff_reg;
  logic [4:0]          tick_cnt_reg;
  logic [4:0]          tick_cnt_next;
  logic [31:0]         tick_div_reg;
  logic                tick;
  logic                check_start;
  logic [3:0]          wait_reg;
  logic [9:0]          eoc_wait_reg;
  dmfm_pkg::dmfm_state_t state_reg;
  logic                ev_amp;
  logic                ev_drag;
  logic                ev_check;
  logic                done_sync;
  logic [11:0]         vel_sync;
  logic [15:0]         amp_sync;
  logic [15:0]         pos_sync;
  logic                rotation;
  logic [15:0]         amp_masked;
  logic [15:0]         pos_delta;
  logic [15:0]         pos_abs;
  logic [11:0]         vel_abs;
  logic [4:0]          divisor;
  logic [11:0]         vel_scaled;
  logic [11:0]         vel_sum;
  logic                wr_ctrl;
  logic                wr_irq_stat;

  assign rotation = ctrl_reg[`DMFM_CTRL_ROTATION];
  assign wr_ctrl = reg_wr && (reg_addr == `DMFM_ADDR_CTRL);
  assign wr_irq_stat = reg_wr && (reg_addr == `DMFM_ADDR_IRQ_STAT);

  // Pin inputs pass the three-stage synchroniser
  dmfm_sync3 #(.W(1)) u_sync_done (
    .sys_clk (sys_clk),
    .srst    (srst),
    .async_in(conversion_done_flag),
    .sync_out(done_sync)
  );
  dmfm_sync3 #(.W(12)) u_sync_vel (
    .sys_clk (sys_clk),
    .srst    (srst),
    .async_in(velocity_sample),
    .sync_out(vel_sync)
  );
  dmfm_sync3 #(.W(16)) u_sync_amp (
    .sys_clk (sys_clk),
    .srst    (srst),
    .async_in(amp_fault_in),
    .sync_out(amp_sync)
  );
  dmfm_sync3 #(.W(16)) u_sync_pos (
    .sys_clk (sys_clk),
    .srst    (srst),
    .async_in(current_position),
    .sync_out(pos_sync)
  );

  // Control tick generator
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick_div_reg <= 32'h0;
      tick <= 1'b0;
    end else if (tick_div_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_div_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_div_reg <= tick_div_reg + 32'h1;
      tick <= 1'b0;
    end
  end

  // Down-counter runs every tick, check pass or not
  always_comb begin
    if (tick_cnt_reg <= 5'h1) begin
      tick_cnt_next = `DMFM_TICK_RELOAD;
    end else begin
      tick_cnt_next = tick_cnt_reg - 5'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick_cnt_reg <= `DMFM_TICK_RELOAD;
    end else if (tick) begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  assign check_start = tick && ctrl_reg[`DMFM_CTRL_ENABLE]
                       && (tick_cnt_next == `DMFM_TICK_CHECK);

  // Position sampled on every tick
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pos_tick_reg <= 16'h0;
    end else if (tick) begin
      pos_tick_reg <= pos_sync;
    end
  end

  // Arithmetic of the check
  assign amp_masked = amp_sync & (rotation ? `DMFM_MASK_ROTATION : `DMFM_MASK_FOCUS);
  assign pos_delta = pos_tick_reg - previous_position;
  assign pos_abs = pos_delta[15] ? (16'h0 - pos_delta) : pos_delta;
  always_comb begin
    if (vel_sync[`DMFM_VEL_SIGN_BIT]) begin
      vel_abs = (12'h0 - vel_sync) & 12'h0fff;
    end else begin
      vel_abs = vel_sync & 12'h0fff;
    end
  end
  assign divisor = rotation ? `DMFM_DIV_ROTATION : `DMFM_DIV_FOCUS;
  // Small constant divisor; remainder simply dropped
  assign vel_scaled = 12'(vel_abs / {7'h0, divisor});
  assign vel_sum = vel_scaled + previous_scaled_velocity;

  // Check sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= dmfm_pkg::ST_IDLE;
      wait_reg <= 4'h0;
      eoc_wait_reg <= 10'h0;
    end else begin
      unique case (state_reg)
        dmfm_pkg::ST_IDLE: begin
          wait_reg <= 4'h0;
          eoc_wait_reg <= 10'h0;
          if (check_start) begin
            state_reg <= dmfm_pkg::ST_AMP;
          end
        end
        dmfm_pkg::ST_AMP: begin
          // Let the fault word cross the synchroniser
          wait_reg <= wait_reg + 4'h1;
          if (wait_reg == `DMFM_SYNC_WAIT) begin
            state_reg <= dmfm_pkg::ST_AMPCK;
          end
        end
        dmfm_pkg::ST_AMPCK: begin
          eoc_wait_reg <= eoc_wait_reg + 10'h1;
          if (amp_masked != 16'h0) begin
            state_reg <= dmfm_pkg::ST_IDLE;
          end else begin
            state_reg <= dmfm_pkg::ST_EOC;
          end
        end
        dmfm_pkg::ST_EOC: begin
          // Stale done level from the last conversion is ignored early on
          if (eoc_wait_reg != 10'h3ff) begin
            eoc_wait_reg <= eoc_wait_reg + 10'h1;
          end
          if (done_sync && eoc_wait_reg > 10'(`DMFM_SYNC_WAIT)) begin
            state_reg <= dmfm_pkg::ST_CALC;
          end
        end
        dmfm_pkg::ST_CALC: begin
          state_reg <= dmfm_pkg::ST_CMP;
        end
        dmfm_pkg::ST_CMP: begin
          state_reg <= dmfm_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= dmfm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Strobes for converter and amplifier, issued as the check opens
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      convert_start_strobe <= 1'b0;
      amp_fault_read_strobe <= 1'b0;
    end else begin
      convert_start_strobe <= check_start && state_reg == dmfm_pkg::ST_IDLE;
      amp_fault_read_strobe <= check_start && state_reg == dmfm_pkg::ST_IDLE;
    end
  end

  // Output port: mux address forced to velocity, upper bits from software
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_port <= `DMFM_PORT_RESET;
    end else if (check_start && state_reg == dmfm_pkg::ST_IDLE) begin
      out_port <= {out_port[15:3], `DMFM_MUX_VELOCITY};
    end else if (reg_wr && reg_addr == `DMFM_ADDR_PORT) begin
      out_port <= reg_wdata[15:0];
    end
  end

  // Amplifier fault copy, focus keeps only the low byte
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      amplifier_fault_word <= 16'h0;
    end else if (state_reg == dmfm_pkg::ST_AMPCK) begin
      amplifier_fault_word <= rotation ? amp_sync : {8'h0, amp_sync[7:0]};
    end
  end

  // Motion history
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      previous_position <= 16'h0;
      previous_scaled_velocity <= 12'h0;
      pos_diff_reg <= 17'h0;
      vel_motion_reg <= 12'h0;
    end else if (state_reg == dmfm_pkg::ST_CALC) begin
      pos_diff_reg <= {1'b0, pos_abs} + `DMFM_POS_BIAS;
      previous_position <= pos_tick_reg;
      vel_motion_reg <= vel_sum;
      previous_scaled_velocity <= vel_scaled;
    end
  end

  // Check events
  assign ev_amp = (state_reg == dmfm_pkg::ST_AMPCK) && (amp_masked != 16'h0);
  assign ev_drag = (state_reg == dmfm_pkg::ST_CMP)
                   && ({5'h0, vel_motion_reg} > pos_diff_reg);
  assign ev_check = (state_reg == dmfm_pkg::ST_CMP);

  // Stop request held for the shutdown logic; set beats software clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      drive_stop_request <= 1'b0;
    end else if (ev_amp || ev_drag) begin
      drive_stop_request <= 1'b1;
    end else if (wr_ctrl && reg_wdata[`DMFM_CTRL_STOP_CLR]) begin
      drive_stop_request <= 1'b0;
    end
  end

  // Main fault word: software writes it, drive fault ORed in over the top
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      main_fault_word <= 16'h0;
    end else begin
      if (reg_wr && reg_addr == `DMFM_ADDR_MAIN_FAULT) begin
        main_fault_word <= reg_wdata[15:0];
      end
      if (ev_drag) begin
        main_fault_word[`DMFM_DRIVE_FAULT_BIT] <= 1'b1;
      end
    end
  end

  // Control register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= `DMFM_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {1'b0, reg_wdata[1:0]};
    end
  end

  // Interrupt status, write one to clear, new events win
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_irq_stat ? reg_wdata[2:0] : 3'h0))
                      | {ev_check, ev_drag, ev_amp};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_mask_reg <= 3'h0;
    end else if (reg_wr && reg_addr == `DMFM_ADDR_IRQ_MASK) begin
      irq_mask_reg <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DMFM_ADDR_CTRL:       reg_rdata <= {29'h0, ctrl_reg};
        `DMFM_ADDR_STATUS:     reg_rdata <= {26'h0, state_reg, done_sync, 1'b0,
                                             drive_stop_request};
        `DMFM_ADDR_MAIN_FAULT: reg_rdata <= {16'h0, main_fault_word};
        `DMFM_ADDR_AMP_FAULT:  reg_rdata <= {16'h0, amplifier_fault_word};
        `DMFM_ADDR_IRQ_STAT:   reg_rdata <= {29'h0, irq_stat_reg};
        `DMFM_ADDR_IRQ_MASK:   reg_rdata <= {29'h0, irq_mask_reg};
        `DMFM_ADDR_PORT:       reg_rdata <= {16'h0, out_port};
        `DMFM_ADDR_POS_DIFF:   reg_rdata <= {15'h0, pos_diff_reg};
        `DMFM_ADDR_VEL_MOTION: reg_rdata <= {20'h0, vel_motion_reg};
        default:               reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule : dmfm_top
`default_nettype wire

// >>> verilog/dmfm_regs.svh
// Register offsets, field positions, reset values and timing counts of the motion monitor
`ifndef DMFM_REGS_SVH
`define DMFM_REGS_SVH

`define DMFM_ADDR_CTRL       8'h00
`define DMFM_ADDR_STATUS     8'h04
`define DMFM_ADDR_MAIN_FAULT 8'h08
`define DMFM_ADDR_AMP_FAULT  8'h0c
`define DMFM_ADDR_IRQ_STAT   8'h10
`define DMFM_ADDR_IRQ_MASK   8'h14
`define DMFM_ADDR_PORT       8'h18
`define DMFM_ADDR_POS_DIFF   8'h1c
`define DMFM_ADDR_VEL_MOTION 8'h20

`define DMFM_CTRL_ENABLE     0
`define DMFM_CTRL_ROTATION   1
`define DMFM_CTRL_STOP_CLR   2

`define DMFM_IRQ_AMP         0
`define DMFM_IRQ_DRAG        1
`define DMFM_IRQ_CHECK       2

`define DMFM_DRIVE_FAULT_BIT 9
`define DMFM_CTRL_RESET      3'h0
`define DMFM_PORT_RESET      16'h0000
`define DMFM_MUX_VELOCITY    3'h1

`define DMFM_TICK_RELOAD     5'h14
`define DMFM_TICK_CHECK      5'h0a
`define DMFM_MASK_ROTATION   16'hfdfd
`define DMFM_MASK_FOCUS      16'h00fd
`define DMFM_DIV_FOCUS       5'h19
`define DMFM_DIV_ROTATION    5'h14
`define DMFM_POS_BIAS        17'h00004
`define DMFM_VEL_SIGN_BIT    11

`define DMFM_CLK_HZ          25000000
`define DMFM_TICK_HZ         1800
`define DMFM_TICK_CYCLES     (`DMFM_CLK_HZ / `DMFM_TICK_HZ)
`define DMFM_EOC_NS          35000
`define DMFM_CLK_NS          40
`define DMFM_EOC_CYCLES      ((`DMFM_EOC_NS + `DMFM_CLK_NS - 1) / `DMFM_CLK_NS)
`define DMFM_SYNC_WAIT       4'h5

`endif

// >>> verilog/dmfm_pkg.sv
// Types shared by the motion monitor
`default_nettype none
package dmfm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_AMP   = 3'b001,
    ST_AMPCK = 3'b010,
    ST_EOC   = 3'b011,
    ST_CALC  = 3'b100,
    ST_CMP   = 3'b101
  } dmfm_state_t;
endpackage : dmfm_pkg
`default_nettype wire

// >>> verilog/dmfm_sync3.sv
// Three-stage input synchroniser that passes a word once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dmfm_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // Async input and its settled copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A word caught mid-change is held back until it settles
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_out <= '0;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end
endmodule : dmfm_sync3
`default_nettype wire

// >>> tb/dmfm_props.sv
// Port checker for the motion monitor, bound to its top
`timescale 1ns/1ps
`default_nettype none
module dmfm_props #(
  parameter int TICK_CYCLES = 40
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Register writes
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Drive side
  input wire logic [15:0] out_port,
  input wire logic        convert_start_strobe,
  input wire logic        amp_fault_read_strobe,
  input wire logic        drive_stop_request
);
  localparam int PERIOD = 20 * TICK_CYCLES;
  int   gap;
  int   since;
  logic seen;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Saturating age, so a stop with no pass behind it stands out
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gap   <= 0;
      since <= 65535;
      seen  <= 1'b0;
    end else if (convert_start_strobe) begin
      gap   <= 1;
      since <= 0;
      seen  <= 1'b1;
    end else begin
      gap   <= gap + 1;
      since <= (since < 65535) ? since + 1 : since;
    end
  end
  sequence s_pass_start;
    convert_start_strobe && amp_fault_read_strobe;
  endsequence
  a_strobes_pair: assert property ((convert_start_strobe || amp_fault_read_strobe) |-> s_pass_start)
    else $error("strobes apart");
  a_strobe_pulse: assert property (s_pass_start |=> !convert_start_strobe && !amp_fault_read_strobe)
    else $error("strobe too long");
  a_mux_select: assert property (s_pass_start |-> out_port[2:0] == 3'h1)
    else $error("mux address wrong");
  a_port_kept: assert property (!(reg_wr && reg_addr == 8'h18) |=> $stable(out_port[15:3]))
    else $error("port bits disturbed");
  a_check_period: assert property (s_pass_start ##0 seen |-> gap == PERIOD)
    else $error("pass spacing wrong");
  a_reset_quiet: assert property ($fell(srst) |-> !drive_stop_request && out_port == 16'h0000)
    else $error("reset state wrong");
  a_stop_cause: assert property ($rose(drive_stop_request) |-> since >= 2 && since <= 1000)
    else $error("stop without pass");
  a_stop_sticky: assert property (drive_stop_request
    && !(reg_wr && reg_addr == 8'h00 && reg_wdata[2]) |=> drive_stop_request)
    else $error("stop dropped");
endmodule : dmfm_props
bind dmfm_top dmfm_props #(.TICK_CYCLES(TICK_CYCLES)) i_dmfm_props (
  .sys_clk(sys_clk),
  .srst(srst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .out_port(out_port),
  .convert_start_strobe(convert_start_strobe),
  .amp_fault_read_strobe(amp_fault_read_strobe),
  .drive_stop_request(drive_stop_request)
);
`default_nettype wire

// >>> tb/dmfm_plant.sv
// Far side model: converter with mux, amplifier discretes, position sensor
`timescale 1ns/1ps
`default_nettype none
module dmfm_plant (
  // Clock and monitor outputs
  input  wire logic        sys_clk,
  input  wire logic [15:0] out_port,
  input  wire logic        convert_start_strobe,
  // Bench settings; eoc_cycles kept at 875 or less
  input  wire logic [15:0] pos_set,
  input  wire logic [11:0] vel_set,
  input  wire logic [15:0] flt_set,
  input  wire logic [9:0]  eoc_cycles,
  // To the monitor
  output logic             conversion_done_flag,
  output logic      [11:0] velocity_sample,
  output logic      [15:0] amp_fault_in,
  output logic      [15:0] current_position
);
  logic [9:0] cnt;
  logic [2:0] chan;
  initial begin
    conversion_done_flag = 1'b1;
    cnt = 10'h000;
    chan = 3'h0;
  end
  // Started by the strobe alone; flag drops at once
  always @(posedge sys_clk) begin
    if (convert_start_strobe) begin
      conversion_done_flag <= 1'b0;
      chan <= out_port[2:0];
      cnt <= eoc_cycles;
    end else if (cnt != 10'h000) begin
      cnt <= cnt - 10'h001;
      conversion_done_flag <= (cnt == 10'h001);
    end
  end
  // Other channel or unfinished conversion reads as garbage
  assign velocity_sample = (conversion_done_flag && chan == 3'h1) ? vel_set : ~vel_set;
  assign amp_fault_in = flt_set;
  assign current_position = pos_set;
endmodule : dmfm_plant
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the motion monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, srst, reg_wr, reg_rd, done, cgo, fgo, stop, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] out_port, flt, pos, pos_set, flt_set, pp, mf;
  logic [11:0] vel, vel_set, pv;
  logic [9:0]  dly_set;
  int          error_cnt, n_tests;
  dmfm_top #(.TICK_CYCLES(40)) i_dmfm_top (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .out_port(out_port), .convert_start_strobe(cgo),
    .conversion_done_flag(done), .velocity_sample(vel), .amp_fault_read_strobe(fgo),
    .amp_fault_in(flt), .current_position(pos), .drive_stop_request(stop), .irq(irq));
  dmfm_plant i_dmfm_plant (.sys_clk(sys_clk), .out_port(out_port),
    .convert_start_strobe(cgo), .pos_set(pos_set), .vel_set(vel_set), .flt_set(flt_set),
    .eoc_cycles(dly_set), .conversion_done_flag(done), .velocity_sample(vel),
    .amp_fault_in(flt), .current_position(pos));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask : rc
  task setup(input logic rot);
    rc(8'h04, 32'h0);
    rc(8'h00, 32'h0);
    rc(8'h3c, 32'h0);
    wr(8'h14, 32'h7);
    wr(8'h18, 32'habc0);
    wr(8'h08, 32'h1);
    mf = 16'h0001;
    wr(8'h00, {30'h0, rot, 1'b1});
  endtask : setup
  task run(input logic rot, input logic [15:0] p, input logic [11:0] v,
           input logic [15:0] f, input logic [9:0] dly, input logic rst);
    logic [15:0] d;
    logic [16:0] pd;
    logic [11:0] sv;
    logic [12:0] m;
    logic        amp, drag;
    int          i;
    @(posedge sys_clk);
    pos_set <= p;
    vel_set <= v;
    flt_set <= f;
    dly_set <= dly;
    if (rst) begin
      srst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      pp = 16'h0000;
      pv = 12'h000;
      setup(rot);
    end
    amp = |(f & (rot ? 16'hfdfd : 16'h00fd));
    d = p - pp;
    pd = {1'b0, d[15] ? -d : d} + 17'h00004;
    sv = (v[11] ? -v : v) / (rot ? 12'h014 : 12'h019);
    m = {1'b0, pv} + {1'b0, sv};
    drag = !amp && (17'(m) > pd);
    // Poll away from the edge that launches irq
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    chk(32'(irq), 32'h1);
    chk(32'(stop), 32'(amp | drag));
    chk(32'(out_port), 32'habc1);
    rc(8'h0c, 32'(rot ? f : f & 16'h00ff));
    rc(8'h10, amp ? 32'h1 : {29'h0, 1'b1, drag, 1'b0});
    if (!amp) begin
      rc(8'h1c, 32'(pd));
      rc(8'h20, 32'(m));
      pp = p;
      pv = sv;
    end
    if (drag) mf = mf | 16'h0200;
    rc(8'h08, 32'(mf));
    wr(8'h10, 32'h7);
    wr(8'h00, {29'h0, 1'b1, rot, 1'b1});
  endtask : run
  task results;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    results();
  end
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    pos_set = 16'h0000;
    vel_set = 12'h000;
    flt_set = 16'h0000;
    dly_set = 10'h014;
    pp = 16'h0000;
    pv = 12'h000;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    setup(1'b1);
    run(1'b1, 16'h0000, 12'h000, 16'h0000, 10'h014, 1'b0);
    // Garbage before done scales one count higher than the real sample
    run(1'b1, 16'h0064, 12'h7cf, 16'h0000, 10'h258, 1'b0);
    run(1'b1, 16'h0000, 12'h830, 16'h0000, 10'h014, 1'b0);
    run(1'b1, 16'h0064, 12'h000, 16'h0202, 10'h014, 1'b0);
    run(1'b1, 16'h0068, 12'h0a0, 16'h0000, 10'h014, 1'b0);
    run(1'b1, 16'h0064, 12'h000, 16'h0100, 10'h014, 1'b0);
    run(1'b0, 16'h0000, 12'h7d0, 16'h0202, 10'h014, 1'b1);
    run(1'b0, 16'h0000, 12'h000, 16'h0001, 10'h014, 1'b0);
    results();
  end
endmodule : tb_top
`default_nettype wire
